// ### dch_pkg.sv
// Shared constants and carrier types for the analog output card register logic.
`default_nettype none
package dch_pkg;
    localparam int unsigned CLK_HZ        = 25_000_000;
    localparam int unsigned CLK_PERIOD_NS = 40;

    // Offsets within the eight-location I/O window.
    localparam logic [2:0] OFS_SAMPLE_LOW  = 3'h0;
    localparam logic [2:0] OFS_SAMPLE_HIGH = 3'h1;
    localparam logic [2:0] OFS_CONTROL     = 3'h2;
    localparam logic [2:0] OFS_HOLD        = 3'h3;
    localparam logic [2:0] OFS_TIMER       = 3'h4;
    localparam logic [2:0] OFS_DIGITAL_IO  = 3'h5;
    localparam logic [2:0] OFS_IRQ         = 3'h6;
    localparam logic [2:0] OFS_SPARE       = 3'h7;

    // Control register fields.
    localparam int CTRL_RESET_BIT      = 7;
    localparam int CTRL_READY_BIT      = 7;
    localparam int CTRL_TIMER_FLAG_BIT = 5;
    localparam int CTRL_EDGE_FLAG_BIT  = 4;
    localparam int CTRL_SOURCE_BIT     = 1;
    localparam int CTRL_RUN_BIT        = 0;
    localparam logic [7:0] CTRL_RESET_VAL  = 8'h00;
    localparam logic [7:0] TIMER_RESET_VAL = 8'h00;

    // Simultaneous output register fields.
    localparam int HOLD_PAIRS     = 4;
    localparam int HOLD_EVENT_BIT = 4;

    // Interrupt enable register fields.
    localparam int IRQ_BITS        = 3;
    localparam int IRQ_TIMER_BIT   = 0;
    localparam int IRQ_EDGE_BIT    = 1;
    localparam int IRQ_LOAD_BIT    = 2;

    // Sample high byte layout.
    localparam int SEL_LSB        = 4;
    localparam int SEL_MSB        = 6;
    localparam int SAMPLE_TOP_MSB = 3;

    // Event timer source rates.
    localparam int unsigned FAST_TICK_HZ = 100_000;
    localparam int unsigned SLOW_TICK_HZ = 1_000;
    localparam int unsigned FAST_DIV     = CLK_HZ / FAST_TICK_HZ;
    localparam int unsigned SLOW_DIV     = CLK_HZ / SLOW_TICK_HZ;

    // Serial transfer into a converter must finish within this time.
    localparam int unsigned XFER_TIME_NS    = 8000;
    localparam int unsigned XFER_CYCLES     = XFER_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned FRAME_BITS      = 16;
    localparam int unsigned HALF_BIT_CYCLES = XFER_CYCLES / (2 * FRAME_BITS);

    typedef struct packed {
        logic [2:0]  select;
        logic [11:0] sample;
    } dch_sample_t;

    typedef struct packed {
        logic        wr;
        logic        rd;
        logic        wide;
        logic [2:0]  addr;
        logic [15:0] wdata;
    } dch_io_req_t;
endpackage : dch_pkg
`default_nettype wire

// ### dch_serial_out.sv
// Serial shifter that loads one sample frame into a converter.
`default_nettype none
module dch_serial_out #(
    parameter int unsigned FRAME_BITS = dch_pkg::FRAME_BITS,
    parameter int unsigned HALF_BIT   = dch_pkg::HALF_BIT_CYCLES
) (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_reset_n,
    input  wire logic                 i_clk_en,
    input  wire logic                 i_start,
    input  wire dch_pkg::dch_sample_t i_word,
    output logic                      o_busy,
    output logic                      o_done,
    output logic                      o_sclk,
    output logic                      o_sdata,
    output logic [2:0]                o_select
);
    localparam int HW = $clog2(HALF_BIT + 1);
    localparam int BW = $clog2(FRAME_BITS + 1);

    typedef enum logic [1:0] {
        DCH_IDLE = 2'b00,
        DCH_LOW  = 2'b01,
        DCH_HIGH = 2'b11
    } dch_shift_state_t;

    dch_shift_state_t        state;
    logic [FRAME_BITS-1:0]   shift;
    logic [HW-1:0]           half_cnt;
    logic [BW-1:0]           bit_cnt;
    logic                    half_end;

    assign half_end = (half_cnt == HW'(HALF_BIT - 1));
    assign o_busy   = (state != DCH_IDLE);
    assign o_sclk   = (state == DCH_HIGH);
    assign o_sdata  = shift[FRAME_BITS-1];

    // The frame is a leading zero bit, select and the untouched sample, so the sample reaches the converter as written.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            state    <= DCH_IDLE;
            shift    <= '0;
            half_cnt <= '0;
            bit_cnt  <= '0;
            o_select <= 3'h0;
            o_done   <= 1'b0;
        end else if (i_clk_en) begin
            o_done <= 1'b0;
            case (state)
                DCH_IDLE: begin
                    if (i_start) begin
                        shift    <= FRAME_BITS'(i_word);
                        o_select <= i_word.select;
                        half_cnt <= '0;
                        bit_cnt  <= '0;
                        state    <= DCH_LOW;
                    end
                end
                DCH_LOW: begin
                    half_cnt <= half_end ? '0 : half_cnt + 1'b1;
                    if (half_end) begin
                        state <= DCH_HIGH;
                    end
                end
                DCH_HIGH: begin
                    half_cnt <= half_end ? '0 : half_cnt + 1'b1;
                    if (half_end) begin
                        shift <= {shift[FRAME_BITS-2:0], 1'b0};
                        if (bit_cnt == BW'(FRAME_BITS - 1)) begin
                            state  <= DCH_IDLE;
                            o_done <= 1'b1;
                        end else begin
                            bit_cnt <= bit_cnt + 1'b1;
                            state   <= DCH_LOW;
                        end
                    end
                end
                default: state <= DCH_IDLE;
            endcase
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    property p_frame_load;
        (i_clk_en && i_start && !o_busy) |=> (o_busy && o_select == $past(i_word.select)
            && shift == FRAME_BITS'($past(i_word)));
    endproperty
    a_frame_load: assert property (p_frame_load) else $error("Frame not loaded from request.");

    property p_done_ends;
        o_done |-> !o_busy && $past(o_busy);
    endproperty
    a_done_ends: assert property (p_done_ends) else $error("Done without a finished frame.");

    c_frame: cover property (o_busy ##1 o_done);
endmodule : dch_serial_out
`default_nettype wire

// ### dch_card_regs.sv
// Host register logic of the eight-channel analog output card.
`default_nettype none
module dch_card_regs #(
    parameter int unsigned FAST_DIV = dch_pkg::FAST_DIV,
    parameter int unsigned SLOW_DIV = dch_pkg::SLOW_DIV
) (
    input  wire logic                 i_ref_clk,
    input  wire logic                 i_reset_n,
    input  wire logic                 i_clk_en,
    input  wire dch_pkg::dch_io_req_t i_io,
    output logic [15:0]               o_io_rdata,
    input  wire logic                 i_outside_edge,
    input  wire logic                 i_outside_load,
    output logic                      o_dac_sclk,
    output logic                      o_dac_sdata,
    output logic [2:0]                o_dac_select,
    output logic [7:0]                o_dac_latch,
    output logic                      o_dac_reset,
    output logic                      o_dac_loading,
    output logic                      o_timer_out
);
    localparam int TW = $clog2(SLOW_DIV + FAST_DIV);

    // Any write that covers location k, either directly or as the upper half of a wide write.
    function automatic logic wr_hit(input dch_pkg::dch_io_req_t r, input logic [2:0] k);
        return r.wr && (r.addr == k || (r.wide && (r.addr + 3'h1) == k));
    endfunction : wr_hit

    function automatic logic [7:0] wr_byte(input dch_pkg::dch_io_req_t r, input logic [2:0] k);
        return (r.addr == k) ? r.wdata[7:0] : r.wdata[15:8];
    endfunction : wr_byte

    logic [7:0]  sample_low;
    logic [7:0]  sample_high;
    logic        run;
    logic        source;
    logic        timer_flag;
    logic        edge_flag;
    logic [3:0]  hold;
    logic        load_flag;
    logic [7:0]  timer_value;
    logic        prev_edge;
    logic        prev_load;
    logic [TW-1:0] tick_cnt;
    logic [7:0]  timer_cnt;
    logic        busy;
    logic        done;
    logic [7:0]  view [8];
    logic        lo_hit, hi_hit, ctrl_hit, hold_hit, timer_hit;
    logic [7:0]  ctrl_byte, hold_byte;
    logic [7:0]  next_low, next_high;
    logic        next_run;
    logic [3:0]  next_hold;
    logic        edge_rise, load_rise, tick, expire;
    logic [TW-1:0] div_last;
    dch_pkg::dch_sample_t word;

    assign lo_hit    = wr_hit(i_io, dch_pkg::OFS_SAMPLE_LOW);
    assign hi_hit    = wr_hit(i_io, dch_pkg::OFS_SAMPLE_HIGH);
    assign ctrl_hit  = wr_hit(i_io, dch_pkg::OFS_CONTROL);
    assign hold_hit  = wr_hit(i_io, dch_pkg::OFS_HOLD);
    assign timer_hit = wr_hit(i_io, dch_pkg::OFS_TIMER);
    assign ctrl_byte = wr_byte(i_io, dch_pkg::OFS_CONTROL);
    assign hold_byte = wr_byte(i_io, dch_pkg::OFS_HOLD);

    // A wide write at the low offset carries both bytes, so the transfer sees the fresh low byte.
    assign next_low  = lo_hit ? wr_byte(i_io, dch_pkg::OFS_SAMPLE_LOW) : sample_low;
    assign next_high = hi_hit ? wr_byte(i_io, dch_pkg::OFS_SAMPLE_HIGH) : sample_high;
    assign word = '{select: next_high[dch_pkg::SEL_MSB:dch_pkg::SEL_LSB],
                    sample: {next_high[dch_pkg::SAMPLE_TOP_MSB:0], next_low}};

    assign next_run  = ctrl_hit ? ctrl_byte[dch_pkg::CTRL_RUN_BIT] : run;
    assign edge_rise = i_outside_edge && !prev_edge;
    assign load_rise = i_outside_load && !prev_load;
    assign next_hold = load_rise ? 4'h0 : (hold_hit ? hold_byte[dch_pkg::HOLD_PAIRS-1:0] : hold);

    assign div_last = source ? TW'(FAST_DIV - 1) : TW'(SLOW_DIV - 1);
    assign tick     = run && (tick_cnt == div_last);
    assign expire   = tick && (timer_cnt == timer_value);
    assign o_dac_loading = !busy;

    dch_serial_out u_shift (
        .i_ref_clk (i_ref_clk),
        .i_reset_n (i_reset_n),
        .i_clk_en  (i_clk_en),
        .i_start   (hi_hit && !busy),
        .i_word    (word),
        .o_busy    (busy),
        .o_done    (done),
        .o_sclk    (o_dac_sclk),
        .o_sdata   (o_dac_sdata),
        .o_select  (o_dac_select)
    );

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sample_low  <= 8'h00;
            sample_high <= 8'h00;
        end else if (i_clk_en) begin
            sample_low  <= next_low;
            sample_high <= next_high;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            run         <= dch_pkg::CTRL_RESET_VAL[dch_pkg::CTRL_RUN_BIT];
            source      <= dch_pkg::CTRL_RESET_VAL[dch_pkg::CTRL_SOURCE_BIT];
            timer_flag  <= dch_pkg::CTRL_RESET_VAL[dch_pkg::CTRL_TIMER_FLAG_BIT];
            edge_flag   <= dch_pkg::CTRL_RESET_VAL[dch_pkg::CTRL_EDGE_FLAG_BIT];
            o_dac_reset <= dch_pkg::CTRL_RESET_VAL[dch_pkg::CTRL_RESET_BIT];
        end else if (i_clk_en) begin
            run         <= next_run;
            o_dac_reset <= ctrl_hit && ctrl_byte[dch_pkg::CTRL_RESET_BIT];
            if (ctrl_hit) begin
                source <= ctrl_byte[dch_pkg::CTRL_SOURCE_BIT];
            end
            if (!next_run) begin
                timer_flag <= 1'b0;
            end else if (expire) begin
                timer_flag <= 1'b1;
            end else if (ctrl_hit && ctrl_byte[dch_pkg::CTRL_TIMER_FLAG_BIT]) begin
                timer_flag <= 1'b0;
            end
            if (edge_rise) begin
                edge_flag <= 1'b1;
            end else if (ctrl_hit && ctrl_byte[dch_pkg::CTRL_EDGE_FLAG_BIT]) begin
                edge_flag <= 1'b0;
            end
        end
    end

    // Outside pins are taken as synchronous; one stage of history is enough for edge detection.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            prev_edge <= 1'b1;
            prev_load <= 1'b1;
        end else if (i_clk_en) begin
            prev_edge <= i_outside_edge;
            prev_load <= i_outside_load;
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            hold      <= 4'h0;
            load_flag <= 1'b0;
        end else if (i_clk_en) begin
            hold <= next_hold;
            if (load_rise) begin
                load_flag <= 1'b1;
            end else if (hold_hit && hold_byte[dch_pkg::HOLD_EVENT_BIT]) begin
                load_flag <= 1'b0;
            end
        end
    end

    // A finished frame converts at once unless its pair is held; releasing a pair converts both channels.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_dac_latch <= 8'h00;
        end else if (i_clk_en) begin
            for (int p = 0; p < dch_pkg::HOLD_PAIRS; p++) begin
                o_dac_latch[2*p]   <= (hold[p] && !next_hold[p])
                    || (done && !hold[p] && o_dac_select == 3'(2*p));
                o_dac_latch[2*p+1] <= (hold[p] && !next_hold[p])
                    || (done && !hold[p] && o_dac_select == 3'(2*p+1));
            end
        end
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            timer_value <= dch_pkg::TIMER_RESET_VAL;
        end else if (i_clk_en) begin
            if (timer_hit) begin
                timer_value <= wr_byte(i_io, dch_pkg::OFS_TIMER);
            end
        end
    end

    // The timer output stays high for one source tick after each expiry.
    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            tick_cnt    <= '0;
            timer_cnt   <= 8'h00;
            o_timer_out <= 1'b0;
        end else if (i_clk_en) begin
            // Stopping drops the output in the same cycle, so a stopped timer never shows a stale expiry.
            if (!run || !next_run) begin
                tick_cnt    <= '0;
                timer_cnt   <= 8'h00;
                o_timer_out <= 1'b0;
            end else begin
                tick_cnt <= tick ? '0 : tick_cnt + 1'b1;
                if (tick) begin
                    timer_cnt   <= expire ? 8'h00 : timer_cnt + 8'h01;
                    o_timer_out <= expire;
                end
            end
        end
    end

    always_comb begin
        // Interrupt generation sits outside this block, so the interrupt location reads zero.
        view = '{default: 8'h00};
        view[dch_pkg::OFS_SAMPLE_LOW]  = sample_low;
        view[dch_pkg::OFS_SAMPLE_HIGH] = sample_high;
        view[dch_pkg::OFS_CONTROL][dch_pkg::CTRL_READY_BIT]      = !busy;
        view[dch_pkg::OFS_CONTROL][dch_pkg::CTRL_TIMER_FLAG_BIT] = timer_flag;
        view[dch_pkg::OFS_CONTROL][dch_pkg::CTRL_EDGE_FLAG_BIT]  = edge_flag;
        view[dch_pkg::OFS_CONTROL][dch_pkg::CTRL_SOURCE_BIT]     = source;
        view[dch_pkg::OFS_CONTROL][dch_pkg::CTRL_RUN_BIT]        = run;
        view[dch_pkg::OFS_HOLD][dch_pkg::HOLD_PAIRS-1:0]         = hold;
        view[dch_pkg::OFS_HOLD][dch_pkg::HOLD_EVENT_BIT]         = load_flag;
        view[dch_pkg::OFS_TIMER]       = timer_value;
    end

    always_ff @(posedge i_ref_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_io_rdata <= 16'h0000;
        end else if (i_clk_en) begin
            if (i_io.rd) begin
                o_io_rdata <= {i_io.wide ? view[i_io.addr + 3'h1] : 8'h00, view[i_io.addr]};
            end
        end
    end

    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_reset_n);

    property p_spare_zero;
        (i_clk_en && i_io.rd && !i_io.wide && i_io.addr == dch_pkg::OFS_SPARE) |=> o_io_rdata == 16'h0000;
    endproperty
    a_spare_zero: assert property (p_spare_zero) else $error("Reserved location read nonzero.");

    property p_low_no_start;
        (i_clk_en && lo_hit && !hi_hit && !busy) |=> !busy;
    endproperty
    a_low_no_start: assert property (p_low_no_start) else $error("Low byte write started a transfer.");

    property p_high_start;
        (i_clk_en && hi_hit && !busy) |=> !o_dac_loading ##1 !o_dac_loading;
    endproperty
    a_high_start: assert property (p_high_start) else $error("Ready did not drop after high write.");

    property p_data_readback;
        (i_clk_en && i_io.rd && !i_io.wr && i_io.wide && i_io.addr == dch_pkg::OFS_SAMPLE_LOW)
            |=> o_io_rdata == {$past(sample_high), $past(sample_low)};
    endproperty
    a_data_readback: assert property (p_data_readback) else $error("Data register readback wrong.");

    property p_ready_read;
        (i_clk_en && i_io.rd && !i_io.wide && i_io.addr == dch_pkg::OFS_CONTROL)
            |=> o_io_rdata[dch_pkg::CTRL_READY_BIT] == !$past(busy) && o_io_rdata[6] == 1'b0
            && o_io_rdata[3:2] == 2'b00;
    endproperty
    a_ready_read: assert property (p_ready_read) else $error("Control read shows wrong ready or reserved.");

    property p_reset_pulse;
        (i_clk_en && ctrl_hit && ctrl_byte[dch_pkg::CTRL_RESET_BIT]) |=> o_dac_reset;
    endproperty
    a_reset_pulse: assert property (p_reset_pulse) else $error("Converter reset not issued.");

    property p_stop_clears;
        !run |-> !timer_flag && !o_timer_out;
    endproperty
    a_stop_clears: assert property (p_stop_clears) else $error("Timer flag set while stopped.");

    property p_timer_clear;
        (i_clk_en && ctrl_hit && ctrl_byte[dch_pkg::CTRL_TIMER_FLAG_BIT] && !expire) |=> !timer_flag;
    endproperty
    a_timer_clear: assert property (p_timer_clear) else $error("Timer flag not cleared by write.");

    property p_edge_wins;
        (i_clk_en && edge_rise) |=> edge_flag;
    endproperty
    a_edge_wins: assert property (p_edge_wins) else $error("Outside edge lost.");

    property p_held_quiet;
        (done && hold[o_dac_select[2:1]] && hold == next_hold && i_clk_en) |=> o_dac_latch == 8'h00;
    endproperty
    a_held_quiet: assert property (p_held_quiet) else $error("Held pair converted.");

    c_high_write: cover property (i_clk_en && hi_hit && !busy);
    c_timer_expire: cover property (i_clk_en && expire);
    c_edge_flag: cover property (i_clk_en && edge_rise);
    c_release: cover property (i_clk_en && |(hold & ~next_hold));
endmodule : dch_card_regs
`default_nettype wire

// ### dch_dac_model.sv
// Behavioural serial converter that records every frame shifted into it.
`default_nettype none
module dch_dac_model (
    input  wire logic        i_sclk,
    input  wire logic        i_sdata,
    input  wire logic        i_loading,
    input  wire logic        i_reset,
    output logic      [15:0] o_word,
    output logic      [7:0]  o_frames
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [15:0] shift;
    initial begin
        o_word   = '0;
        o_frames = '0;
        shift    = '0;
    end
    // Bits are only taken while the card signals a transfer in progress.
    always @(posedge i_sclk) begin
        if (i_loading === 1'b0) shift <= {shift[14:0], i_sdata};
    end
    always @(posedge i_loading) begin
        o_word = shift;
        o_frames++;
    end
    always @(posedge i_reset) o_word = '0;
endmodule : dch_dac_model
`default_nettype wire

// ### dch_card_regs_tb.sv
// Self-checking bench for the card register logic.
`default_nettype none
module dch_card_regs_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic                 clk;
    logic                 rst_n;
    logic                 edge_in;
    dch_pkg::dch_io_req_t io;
    logic [15:0]          rdata;
    logic                 sclk, sdata, dreset, loading, tout;
    logic                 clk_en, load_in, tout_seen;
    logic [2:0]           dsel;
    logic [7:0]           latch, lat_seen, frames, f0;
    logic [15:0]          word;
    logic                 rst_seen;
    int                   fails, checked;
    initial begin
        clk = 1'b0;
        forever #20 clk = ~clk;
    end
    dch_card_regs #(.FAST_DIV(4), .SLOW_DIV(8)) dut (.i_ref_clk(clk), .i_reset_n(rst_n), .i_clk_en(clk_en),
        .i_io(io), .o_io_rdata(rdata), .i_outside_edge(edge_in), .i_outside_load(load_in), .o_dac_sclk(sclk),
        .o_dac_sdata(sdata), .o_dac_select(dsel), .o_dac_latch(latch), .o_dac_reset(dreset),
        .o_dac_loading(loading), .o_timer_out(tout));
    dch_dac_model dac (.i_sclk(sclk), .i_sdata(sdata), .i_loading(loading), .i_reset(dreset),
        .o_word(word), .o_frames(frames));
    // Short output pulses (latch and reset for one cycle, timer output for one tick) are made sticky so the sequence can look at them later.
    always @(posedge clk) begin
        if (latch !== 8'h00) lat_seen <= latch;
        if (dreset === 1'b1) rst_seen <= 1'b1;
        if (tout === 1'b1) tout_seen <= 1'b1;
    end
    task automatic complete_run;
        $display("checked %0d fails %0d", checked, fails);
        if (fails == 0 && checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : complete_run
    task automatic chk(input string n, input logic [15:0] e, input logic [15:0] s);
        checked++;
        if (s !== e) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", n, e, s);
        end
    endtask : chk
    // One access: request for one cycle, then an idle cycle before the next.
    task automatic acc(input logic r, input logic [2:0] a, input logic [15:0] d, input logic w);
        io = '{wr: !r, rd: r, wide: w, addr: a, wdata: d};
        @(negedge clk);
        io = '0;
        @(negedge clk);
    endtask : acc
    task automatic rd(input logic [2:0] a, input string n, input logic [15:0] e);
        acc(1'b1, a, 16'h0000, 1'b0);
        chk(n, e, rdata);
    endtask : rd
    task automatic frame(input logic [2:0] s, input logic [11:0] v, input logic w);
        lat_seen = 8'h00;
        f0 = frames;
        if (w) acc(1'b0, 3'h0, {1'b0, s, v}, 1'b1);
        else begin
            acc(1'b0, 3'h0, {8'h00, v[7:0]}, 1'b0);
            acc(1'b0, 3'h1, {8'h00, 1'b0, s, v[11:8]}, 1'b0);
        end
        rd(3'h2, "ready busy", 16'h0000);
        acc(1'b1, 3'h0, 16'h0000, 1'b1);
        chk("readback busy", {1'b0, s, v}, rdata);
        for (int i = 0; i < 400 && loading !== 1'b1; i++) @(negedge clk);
        repeat (3) @(negedge clk);
        chk("frame word", {1'b0, s, v}, word);
        chk("select", {13'h0000, s}, {13'h0000, dsel});
        chk("frame count", f0 + 8'h01, frames);
        chk("latch", 16'h0001 << s, lat_seen);
        rd(3'h2, "ready idle", 16'h0080);
    endtask : frame
    initial begin
        rst_n = 1'b0;
        io = '0;
        edge_in = 1'b0;
        lat_seen = 8'h00;
        rst_seen = 1'b0;
        clk_en = 1'b1;
        load_in = 1'b0;
        tout_seen = 1'b0;
        repeat (10) @(negedge clk);
        rst_n = 1'b1;
        @(negedge clk);
        rd(3'h2, "control reset", 16'h0080);
        frame(3'h5, 12'habc, 1'b0);
        frame(3'h2, 12'h800, 1'b1);
        frame(3'h7, 12'hfff, 1'b1);
        acc(1'b0, 3'h3, 16'h0004, 1'b0);
        lat_seen = 8'h00;
        acc(1'b0, 3'h0, 16'h5123, 1'b1);
        for (int i = 0; i < 400 && loading !== 1'b1; i++) @(negedge clk);
        repeat (3) @(negedge clk);
        chk("held word", 16'h5123, word);
        chk("held latch", 16'h0000, {8'h00, lat_seen});
        rd(3'h3, "hold readback", 16'h0004);
        acc(1'b0, 3'h3, 16'h0000, 1'b0);
        chk("release latch", 16'h0030, {8'h00, lat_seen});
        acc(1'b0, 3'h3, 16'h0001, 1'b0);
        lat_seen = 8'h00;
        load_in = 1'b1;
        repeat (2) @(negedge clk);
        chk("load latch", 16'h0003, {8'h00, lat_seen});
        rd(3'h3, "load event", 16'h0010);
        acc(1'b0, 3'h3, 16'h0010, 1'b0);
        rd(3'h3, "load clear", 16'h0000);
        f0 = frames;
        acc(1'b0, 3'h0, 16'h0055, 1'b0);
        repeat (20) @(negedge clk);
        chk("low only", {8'h00, f0}, {8'h00, frames});
        acc(1'b1, 3'h0, 16'h0000, 1'b0);
        chk("low stored", 16'h0055, rdata);
        clk_en = 1'b0;
        acc(1'b0, 3'h0, 16'h00aa, 1'b0);
        clk_en = 1'b1;
        rd(3'h0, "clock enable freeze", 16'h0055);
        acc(1'b0, 3'h2, 16'h0080, 1'b0);
        chk("converter reset", 16'h0001, {15'h0000, rst_seen});
        chk("reset output", 16'h0000, word);
        rd(3'h2, "reset clears", 16'h0080);
        acc(1'b0, 3'h2, 16'h004e, 1'b0);
        rd(3'h2, "reserved zero", 16'h0082);
        acc(1'b0, 3'h2, 16'h0000, 1'b0);
        edge_in = 1'b1;
        repeat (3) @(negedge clk);
        rd(3'h2, "edge flag", 16'h0090);
        acc(1'b0, 3'h2, 16'h0010, 1'b0);
        rd(3'h2, "edge clear", 16'h0080);
        edge_in = 1'b0;
        acc(1'b0, 3'h4, 16'h0002, 1'b0);
        acc(1'b0, 3'h2, 16'h0001, 1'b0);
        repeat (60) @(negedge clk);
        rd(3'h2, "timer flag", 16'h00a1);
        chk("timer output", 16'h0001, {15'h0000, tout_seen});
        acc(1'b0, 3'h2, 16'h0000, 1'b0);
        rd(3'h2, "timer stop", 16'h0080);
        acc(1'b0, 3'h7, 16'h00ff, 1'b0);
        rd(3'h7, "reserved offset", 16'h0000);
        complete_run();
    end
    // The full sequence needs about 950 cycles; far beyond that means a hang.
    initial begin
        #(20000 * 40);
        fails++;
        complete_run();
    end
endmodule : dch_card_regs_tb
`default_nettype wire
